//--- pkt_framer.sv
// basic packet framer and deframer with register port and interrupt
`timescale 1ns/10ps

module pkt_framer
  import pkt_framer_pkg::*;
(
  input wire logic sys_clk, // core clock, 25 MHz
  input wire logic rstn, // synchronous reset, active low
  input wire logic [7:0] regAddr, // register index
  input wire logic [7:0] regWrData, // register write data
  input wire logic regWrEn, // write strobe
  input wire logic regRdEn, // read strobe
  output logic [7:0] regRdData, // read data, cycle after strobe
  output logic irq, // level interrupt
  input wire logic [7:0] txByte, // byte from tx fifo
  input wire logic txByteValid, // tx fifo holds a byte
  output logic txByteReady, // byte taken this cycle
  output logic txBit, // air bit to modulator
  output logic txBitValid, // air bit offered
  input wire logic txBitReady, // modulator takes the bit
  input wire logic rxBit, // air bit from demodulator
  input wire logic rxBitValid, // air bit strobe
  output logic [7:0] rxByte, // byte to rx fifo
  output logic rxByteValid // rx byte strobe
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [CFG_WORDS-1:0][7:0] cfg;
    logic [7:0] status;
    logic [7:0] mask;
    logic [6:0] sync_quality_index;
    logic [15:0] rxLen;
    logic [7:0] rdData;
    logic rxOn;
    tx_state_t tState;
    logic [31:0] tSh;
    logic [11:0] tBitCnt;
    logic [15:0] tByteCnt;
    logic [7:0] tCrc;
    rx_state_t rState;
    logic [31:0] rHist;
    logic preSeen;
    logic [11:0] rBitCnt;
    logic [15:0] rByteCnt;
    logic [7:0] rCrc;
    logic [7:0] rxByte;
    logic rxByteValid;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  // ----------------------------------------------------------------
  // configuration decode
  // ----------------------------------------------------------------
  logic [7:0] ctrl;
  logic [1:0] fmt;
  logic varLen;
  logic lenWid;
  logic addrEn;
  logic crcEn;
  logic altSync;
  logic [3:0] prePat;
  logic [11:0] preBits;
  logic [5:0] syncLen;
  logic [31:0] priWord;
  logic [31:0] secWord;
  logic [31:0] syncMask;
  logic [7:0] nodeAddr;
  logic [15:0] txLen;
  logic [15:0] payTx;
  logic [15:0] payRx;
  logic [31:0] histNew;
  logic [5:0] priCnt;
  logic [5:0] secCnt;
  logic priHit;
  logic secHit;
  logic preDet;
  logic txAdv;
  logic rxShift;
  logic [7:0] ev;

  assign ctrl = st_r.cfg[REG_PKT_CTRL[3:0]];
  assign fmt = ctrl[PKT_FMT_LSB +: 2];
  assign varLen = ctrl[VARLEN_BIT];
  assign lenWid = ctrl[LENWID_BIT];
  assign addrEn = ctrl[ADDR_EN_BIT];
  assign crcEn = ctrl[CRC_EN_BIT];
  assign altSync = ctrl[ALT_SYNC_BIT];
  assign prePat = ctrl[FSK4_BIT] ?
                  PRE_PAT_4[st_r.cfg[REG_PRE_SEL[3:0]][1:0]] :
                  PRE_PAT_2[st_r.cfg[REG_PRE_SEL[3:0]][1:0]];
  // pair count to bit count
  assign preBits = {st_r.cfg[REG_PRE_CNT_HI[3:0]][2:0],
                    st_r.cfg[REG_PRE_CNT_LO[3:0]], 1'b0};
  // lengths above 32 are clamped
  assign syncLen = (st_r.cfg[REG_SYNC_LEN[3:0]][5:0] > SYNC_MAX) ?
                   SYNC_MAX : st_r.cfg[REG_SYNC_LEN[3:0]][5:0];
  // first byte in the top bits so it goes out msb first
  assign priWord = {st_r.cfg[4'h5], st_r.cfg[4'h6],
                    st_r.cfg[4'h7], st_r.cfg[4'h8]};
  assign secWord = {st_r.cfg[REG_SYNC_SEC1[3:0]], st_r.cfg[4'hA],
                    st_r.cfg[4'hB], st_r.cfg[4'hC]};
  // node address shares storage with the last secondary sync byte
  assign nodeAddr = st_r.cfg[REG_NODE_ADDR[3:0]];
  assign txLen = {st_r.cfg[REG_TXLEN_HI[3:0]],
                  st_r.cfg[REG_TXLEN_LO[3:0]]};
  // length counts payload plus address byte
  assign payTx = (addrEn && txLen != 16'h0000) ? txLen - 16'h0001 : txLen;
  assign payRx = (addrEn && st_r.rxLen != 16'h0000) ?
                 st_r.rxLen - 16'h0001 : st_r.rxLen;

  // ----------------------------------------------------------------
  // receive correlators
  // ----------------------------------------------------------------
  assign histNew = {st_r.rHist[30:0], rxBit};
  assign syncMask = 32'hFFFFFFFF >> (SYNC_MAX - syncLen);
  assign priCnt = popCount(~(histNew ^ (priWord >> (SYNC_MAX - syncLen)))
                           & syncMask);
  assign secCnt = popCount(~(histNew ^ (secWord >> (SYNC_MAX - syncLen)))
                           & syncMask);
  assign priHit = priCnt == syncLen;
  assign secHit = altSync && secCnt == syncLen;
  // two repeats of any phase of the selected pattern
  assign preDet = histNew[7:4] == histNew[3:0] &&
                  (histNew[3:0] == prePat ||
                   histNew[3:0] == {prePat[2:0], prePat[3]} ||
                   histNew[3:0] == {prePat[1:0], prePat[3:2]} ||
                   histNew[3:0] == {prePat[0], prePat[3:1]});

  // ----------------------------------------------------------------
  // handshakes and outputs
  // ----------------------------------------------------------------
  assign txBitValid = st_r.tState != T_IDLE && st_r.tBitCnt != 12'h000;
  assign txAdv = txBitValid && txBitReady;
  assign txBit = st_r.tSh[31];
  assign txByteReady = st_r.tState == T_PAY && st_r.tBitCnt == 12'h000 &&
                       st_r.tByteCnt != 16'h0000;
  assign rxShift = rxBitValid && st_r.rBitCnt != 12'h000 &&
                   st_r.rState != R_IDLE && st_r.rState != R_SEARCH;
  assign regRdData = st_r.rdData;
  assign rxByte = st_r.rxByte;
  assign rxByteValid = st_r.rxByteValid;
  assign irq = |(st_r.status & st_r.mask);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    ev = 8'h00;
    st_nxt.rxByteValid = 1'b0;
    st_nxt.rdData = 8'h00;

    // transmit bit engine
    if (txAdv) begin
      st_nxt.tBitCnt = st_r.tBitCnt - 12'h001;
      if (st_r.tState == T_PRE || st_r.tState == T_POST) begin
        st_nxt.tSh = {st_r.tSh[30:0], st_r.tSh[31]};
      end else begin
        st_nxt.tSh = {st_r.tSh[30:0], 1'b0};
      end
      if (st_r.tState == T_LEN || st_r.tState == T_ADDR ||
          st_r.tState == T_PAY) begin
        st_nxt.tCrc = crcStep(st_r.tCrc, st_r.tSh[31]);
      end
    end else if (st_r.tBitCnt == 12'h000) begin
      // field order and zero-length skipping
      case (st_r.tState)
        T_IDLE: begin
        end
        T_PRE: begin
          st_nxt.tState = T_SYNC;
          st_nxt.tSh = altSync ? secWord : priWord;
          st_nxt.tBitCnt = {6'h00, syncLen};
        end
        T_SYNC: begin
          st_nxt.tState = T_LEN;
          st_nxt.tCrc = CRC_INIT;
          st_nxt.tSh = lenWid ? {txLen, 16'h0000} : {txLen[7:0], 24'h000000};
          st_nxt.tBitCnt = !varLen ? 12'h000 : lenWid ? BITS_WORD : BITS_BYTE;
        end
        T_LEN: begin
          st_nxt.tState = T_ADDR;
          st_nxt.tSh = {nodeAddr, 24'h000000};
          st_nxt.tBitCnt = addrEn ? BITS_BYTE : 12'h000;
        end
        T_ADDR: begin
          st_nxt.tState = T_PAY;
          st_nxt.tByteCnt = payTx;
        end
        T_PAY: begin
          if (st_r.tByteCnt != 16'h0000) begin
            if (txByteValid) begin
              st_nxt.tSh = {txByte, 24'h000000};
              st_nxt.tBitCnt = BITS_BYTE;
              st_nxt.tByteCnt = st_r.tByteCnt - 16'h0001;
            end
          end else begin
            st_nxt.tState = T_CRC;
            st_nxt.tSh = {st_r.tCrc, 24'h000000};
            st_nxt.tBitCnt = crcEn ? BITS_BYTE : 12'h000;
          end
        end
        T_CRC: begin
          st_nxt.tState = T_POST;
          st_nxt.tSh = POST_PATTERN;
          st_nxt.tBitCnt = {3'h0, st_r.cfg[REG_POST_CNT[3:0]], 1'b0};
        end
        T_POST: begin
          st_nxt.tState = T_IDLE;
          ev[ST_TX_DONE] = 1'b1;
        end
        default: begin
          st_nxt.tState = T_IDLE;
        end
      endcase
    end

    // receive engine
    if (st_r.rState == R_SEARCH) begin
      if (rxBitValid) begin
        st_nxt.rHist = histNew;
        if (preDet) begin
          st_nxt.preSeen = 1'b1;
        end
        if ((st_r.preSeen || preBits == 12'h000) && (priHit || secHit)) begin
          st_nxt.sync_quality_index = {secHit && !priHit,
                        (secHit && secCnt > priCnt) ? secCnt : priCnt};
          ev[ST_SYNC] = 1'b1;
          st_nxt.rCrc = CRC_INIT;
          st_nxt.rState = R_LEN;
          st_nxt.rBitCnt = !varLen ? 12'h000 : lenWid ? BITS_WORD : BITS_BYTE;
        end
      end
    end else if (rxShift) begin
      st_nxt.rHist = histNew;
      st_nxt.rBitCnt = st_r.rBitCnt - 12'h001;
      if (st_r.rState != R_CRC) begin
        st_nxt.rCrc = crcStep(st_r.rCrc, rxBit);
      end
      if (st_r.rState == R_PAY && st_r.rBitCnt == 12'h001) begin
        st_nxt.rxByte = histNew[7:0];
        st_nxt.rxByteValid = 1'b1;
        st_nxt.rByteCnt = st_r.rByteCnt - 16'h0001;
      end
    end else if (st_r.rBitCnt == 12'h000) begin
      case (st_r.rState)
        R_IDLE, R_SEARCH: begin
        end
        R_LEN: begin
          if (varLen) begin
            st_nxt.rxLen = lenWid ? st_r.rHist[15:0] :
                           {8'h00, st_r.rHist[7:0]};
          end else begin
            st_nxt.rxLen = txLen;
          end
          st_nxt.rState = R_ADDR;
          st_nxt.rBitCnt = addrEn ? BITS_BYTE : 12'h000;
        end
        R_ADDR: begin
          if (addrEn && st_r.rHist[7:0] != nodeAddr) begin
            ev[ST_ADDR_REJ] = 1'b1;
            st_nxt.rState = R_SEARCH;
            st_nxt.preSeen = 1'b0;
          end else begin
            st_nxt.rState = R_PAY;
            st_nxt.rByteCnt = payRx;
          end
        end
        R_PAY: begin
          if (st_r.rByteCnt != 16'h0000) begin
            st_nxt.rBitCnt = BITS_BYTE;
          end else begin
            st_nxt.rState = R_CRC;
            st_nxt.rBitCnt = crcEn ? BITS_BYTE : 12'h000;
          end
        end
        R_CRC: begin
          if (crcEn && st_r.rHist[7:0] != st_r.rCrc) begin
            ev[ST_CRC_ERR] = 1'b1;
          end else begin
            ev[ST_PKT_OK] = 1'b1;
          end
          st_nxt.rState = R_SEARCH;
          st_nxt.preSeen = 1'b0;
        end
        default: begin
          st_nxt.rState = R_IDLE;
        end
      endcase
    end

    // register writes and commands
    if (regWrEn) begin
      if (regAddr < REG_CMD) begin
        st_nxt.cfg[regAddr[3:0]] = regWrData;
      end
      if (regAddr == REG_MASK) begin
        st_nxt.mask = regWrData;
      end
      if (regAddr == REG_CMD) begin
        if (regWrData[CMD_TX_BIT] && st_r.tState == T_IDLE) begin
          if (fmt == FMT_BASIC) begin
            st_nxt.tState = T_PRE;
            st_nxt.tSh = {8{prePat}};
            st_nxt.tBitCnt = preBits;
          end else begin
            ev[ST_FMT_ERR] = 1'b1;
          end
        end
        if (regWrData[CMD_RX_BIT]) begin
          if (fmt == FMT_BASIC) begin
            st_nxt.rxOn = 1'b1;
            st_nxt.rState = R_SEARCH;
            st_nxt.preSeen = 1'b0;
            st_nxt.rBitCnt = 12'h000;
          end else begin
            ev[ST_FMT_ERR] = 1'b1;
          end
        end
        if (regWrData[CMD_ABORT_BIT]) begin
          st_nxt.tState = T_IDLE;
          st_nxt.tBitCnt = 12'h000;
          st_nxt.rState = R_IDLE;
          st_nxt.rBitCnt = 12'h000;
          st_nxt.rxOn = 1'b0;
        end
      end
    end

    // register reads, status clears on read, new events win
    st_nxt.status = st_r.status | ev;
    if (regRdEn) begin
      case (regAddr)
        REG_STATUS: begin
          st_nxt.rdData = st_r.status;
          st_nxt.status = ev;
        end
        REG_MASK: st_nxt.rdData = st_r.mask;
        REG_LINK_QUAL: st_nxt.rdData = {1'b0, st_r.sync_quality_index};
        REG_RXLEN_HI: st_nxt.rdData = st_r.rxLen[15:8];
        REG_RXLEN_LO: st_nxt.rdData = st_r.rxLen[7:0];
        REG_STATE: st_nxt.rdData = {1'b0, st_r.rxOn, st_r.rState,
                                    st_r.tState};
        default: begin
          if (regAddr < REG_CMD) begin
            st_nxt.rdData = st_r.cfg[regAddr[3:0]];
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      st_r <= '0;
      st_r.cfg <= {CFG_WORDS{CFG_RESET}};
      st_r.status <= STATUS_RESET;
      st_r.mask <= MASK_RESET;
      st_r.tState <= T_IDLE;
      st_r.rState <= R_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule // pkt_framer

//--- pkt_framer_pkg.sv
// constants, types and helpers for the basic packet framer and deframer
package pkt_framer_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte-wide registers, index addressed)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_PKT_CTRL = 8'h00;
  localparam logic [7:0] REG_PRE_SEL = 8'h01;
  localparam logic [7:0] REG_PRE_CNT_HI = 8'h02;
  localparam logic [7:0] REG_PRE_CNT_LO = 8'h03;
  localparam logic [7:0] REG_SYNC_LEN = 8'h04;
  localparam logic [7:0] REG_SYNC_PRI1 = 8'h05;
  localparam logic [7:0] REG_SYNC_SEC1 = 8'h09;
  localparam logic [7:0] REG_NODE_ADDR = 8'h0C;
  localparam logic [7:0] REG_TXLEN_HI = 8'h0D;
  localparam logic [7:0] REG_TXLEN_LO = 8'h0E;
  localparam logic [7:0] REG_POST_CNT = 8'h0F;
  localparam logic [7:0] REG_CMD = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h11;
  localparam logic [7:0] REG_MASK = 8'h12;
  localparam logic [7:0] REG_LINK_QUAL = 8'h13;
  localparam logic [7:0] REG_RXLEN_HI = 8'h14;
  localparam logic [7:0] REG_RXLEN_LO = 8'h15;
  localparam logic [7:0] REG_STATE = 8'h16;
  localparam int CFG_WORDS = 16;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int PKT_FMT_LSB = 0;
  localparam int VARLEN_BIT = 2;
  localparam int LENWID_BIT = 3;
  localparam int ADDR_EN_BIT = 4;
  localparam int CRC_EN_BIT = 5;
  localparam int ALT_SYNC_BIT = 6;
  localparam int FSK4_BIT = 7;
  localparam int CMD_TX_BIT = 0;
  localparam int CMD_RX_BIT = 1;
  localparam int CMD_ABORT_BIT = 2;
  localparam int ST_TX_DONE = 0;
  localparam int ST_SYNC = 1;
  localparam int ST_CRC_ERR = 2;
  localparam int ST_PKT_OK = 3;
  localparam int ST_ADDR_REJ = 4;
  localparam int ST_FMT_ERR = 5;

  // ----------------------------------------------------------------
  // reset values, encodings, patterns
  // ----------------------------------------------------------------
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [1:0] FMT_BASIC = 2'h0;
  localparam logic [1:0] FMT_154G = 2'h1;
  localparam logic [1:0] FMT_UART = 2'h2;
  localparam logic [1:0] FMT_ACKED = 2'h3;
  localparam logic [3:0] PRE_PAT_2 [4] = '{4'h5, 4'hA, 4'hC, 4'h3};
  localparam logic [3:0] PRE_PAT_4 [4] = '{4'h7, 4'h2, 4'hD, 4'h8};
  localparam logic [31:0] POST_PATTERN = 32'h55555555;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'hFF;
  localparam logic [5:0] SYNC_MAX = 6'h20;
  localparam logic [11:0] BITS_BYTE = 12'h008;
  localparam logic [11:0] BITS_WORD = 12'h010;

  typedef enum logic [2:0] {
    T_IDLE = 3'b000, T_PRE = 3'b001, T_SYNC = 3'b010, T_LEN = 3'b011,
    T_ADDR = 3'b100, T_PAY = 3'b101, T_CRC = 3'b110, T_POST = 3'b111
  } tx_state_t;

  typedef enum logic [2:0] {
    R_IDLE = 3'b000, R_SEARCH = 3'b001, R_LEN = 3'b010, R_ADDR = 3'b011,
    R_PAY = 3'b100, R_CRC = 3'b101
  } rx_state_t;

  function automatic logic [7:0] crcStep(input logic [7:0] c,
                                         input logic b);
    logic fb;
    fb = c[7] ^ b;
    return fb ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
  endfunction

  function automatic logic [5:0] popCount(input logic [31:0] v);
    logic [5:0] n;
    n = 6'h00;
    for (int i = 0; i < 32; i++) begin
      n = n + {5'h00, v[i]};
    end
    return n;
  endfunction

endpackage

//--- pkt_framer_monitor.sv
// port checker for the packet framer
`timescale 1ns/10ps
module pkt_framer_monitor
  import pkt_framer_pkg::*;
(
  input wire logic sys_clk, // clock
  input wire logic rstn, // reset
  input wire logic [7:0] regAddr, // index
  input wire logic [7:0] regWrData, // wdata
  input wire logic regWrEn, // write
  input wire logic regRdEn, // read
  input wire logic [7:0] regRdData, // rdata
  input wire logic irq, // interrupt
  input wire logic [7:0] txByte, // fifo data
  input wire logic txByteValid, // fifo valid
  input wire logic txByteReady, // fifo take
  input wire logic txBit, // air out
  input wire logic txBitValid, // air valid
  input wire logic txBitReady, // air take
  input wire logic rxBit, // air in
  input wire logic rxBitValid, // air strobe
  input wire logic [7:0] rxByte, // rx byte
  input wire logic rxByteValid // rx strobe
);
  // ----------------------------------------------------------
  // shadows of the settings behind the first air bit
  // ----------------------------------------------------------
  logic [7:0] ctrlSh;
  logic [1:0] selSh;
  logic [10:0] preSh;
  logic [2:0] lowCnt;
  logic [3:0] firstPat;
  logic txStart;
  // a start only counts once the sender has been quiet a while
  assign txStart = regWrEn && regAddr == REG_CMD && regWrData[CMD_TX_BIT]
    && !regWrData[CMD_ABORT_BIT] && lowCnt == 3'h7;
  assign firstPat = ctrlSh[FSK4_BIT] ? PRE_PAT_4[selSh] : PRE_PAT_2[selSh];
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ctrlSh <= 8'h00;
      selSh <= 2'h0;
      preSh <= 11'h000;
      lowCnt <= 3'h0;
    end else begin
      if (regWrEn && regAddr == REG_PKT_CTRL) ctrlSh <= regWrData;
      if (regWrEn && regAddr == REG_PRE_SEL) selSh <= regWrData[1:0];
      if (regWrEn && regAddr == REG_PRE_CNT_HI) begin
        preSh[10:8] <= regWrData[2:0];
      end
      if (regWrEn && regAddr == REG_PRE_CNT_LO) preSh[7:0] <= regWrData;
      if (txBitValid) lowCnt <= 3'h0;
      else if (lowCnt != 3'h7) lowCnt <= lowCnt + 3'h1;
    end
  end
  // ----------------------------------------------------------
  // assertions
  // ----------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  sequence basicGo;
    txStart && ctrlSh[1:0] == FMT_BASIC && preSh != 11'h000;
  endsequence
  sequence otherGo;
    txStart && ctrlSh[1:0] != FMT_BASIC;
  endsequence
  chk_pre_first: assert property (
    basicGo |=> txBitValid && txBit == firstPat[3])
    else $error("first air bit not pattern msb");
  chk_fmt_refuse: assert property (
    otherGo |=> !txBitValid [*8])
    else $error("air bits for non-basic format");
  chk_bit_hold: assert property (
    txBitValid && !txBitReady |=> txBitValid && $stable(txBit))
    else $error("air bit changed before taken");
  chk_fifo_gap: assert property (
    txByteReady |-> !txBitValid)
    else $error("fifo byte taken mid bit");
  chk_rx_byte: assert property (
    rxByteValid |-> $past(rxBitValid) ##1 !rxByteValid [*4])
    else $error("rx byte strobe off its bit");
  chk_rd_idle: assert property (
    !$past(regRdEn) |-> regRdData == 8'h00)
    else $error("read data outside read cycle");
  chk_rd_unmapped: assert property (
    regRdEn && regAddr > REG_STATE |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
  chk_mask_off: assert property (
    regWrEn && regAddr == REG_MASK && regWrData == 8'h00 |=> !irq)
    else $error("irq with mask cleared");
endmodule // pkt_framer_monitor

bind pkt_framer pkt_framer_monitor i_mon (.sys_clk, .rstn, .regAddr,
  .regWrData, .regWrEn, .regRdEn, .regRdData, .irq, .txByte, .txByteValid,
  .txByteReady, .txBit, .txBitValid, .txBitReady, .rxBit, .rxBitValid,
  .rxByte, .rxByteValid);

//--- air_link_model.sv
// modulator and demodulator model that echoes air bits back
`timescale 1ns/10ps
module air_link_model (
  input wire logic sys_clk, // clock
  input wire logic rstn, // reset
  input wire logic txBit, // air bit in
  input wire logic txBitValid, // bit offered
  output logic txBitReady, // bit taken
  output logic rxBit, // echoed bit
  output logic rxBitValid // echo strobe
);
  logic [2:0] gapCnt;
  logic capBits [$];
  // slow taker: one bit in six cycles keeps echoes legally apart
  assign txBitReady = (gapCnt == 3'h5);
  always @(posedge sys_clk) begin
    if (!rstn) begin
      gapCnt <= 3'h0;
      rxBit <= 1'b0;
      rxBitValid <= 1'b0;
    end else begin
      gapCnt <= (gapCnt == 3'h5) ? 3'h0 : gapCnt + 3'h1;
      rxBitValid <= txBitValid && txBitReady;
      // outside a strobe the line toggles so stale values never match
      rxBit <= (txBitValid && txBitReady) ? txBit : ~rxBit;
      if (txBitValid && txBitReady) capBits.push_back(txBit);
    end
  end
endmodule // air_link_model

//--- testbench.sv
// self-checking bench for the packet framer
`timescale 1ns/10ps
module testbench
  import pkt_framer_pkg::*;
;
  logic sys_clk, rstn, regWrEn, regRdEn, irq, txByteValid, txByteReady;
  logic txBit, txBitValid, txBitReady, rxBit, rxBitValid, rxByteValid;
  logic [7:0] regAddr, regWrData, regRdData, txByte, rxByte, lastRx, crc;
  logic expQ [$];
  logic [7:0] pay [4] = '{8'hC7, 8'h19, 8'h00, 8'h00};
  int error_cnt, num_checks, cycCnt, payIdx;
  localparam logic [7:0] C_CTRL [3] = '{8'h34, 8'h6C, 8'h80};
  localparam logic [7:0] C_SEL [3] = '{8'h01, 8'h02, 8'h03};
  localparam logic [7:0] C_SLEN [3] = '{8'h0C, 8'h10, 8'h08};
  localparam logic [7:0] C_LEN [3] = '{8'h03, 8'h02, 8'h01};
  localparam logic [7:0] C_POST [3] = '{8'h02, 8'h01, 8'h00};
  localparam logic [31:0] PRI = 32'hA5C396F0;
  localparam logic [31:0] SEC = 32'h3A5E003C;
  localparam logic [7:0] R0 [6] = '{REG_PKT_CTRL, REG_STATUS, REG_MASK,
    REG_LINK_QUAL, REG_STATE, 8'h30};

  pkt_framer i_dut (.sys_clk, .rstn, .regAddr, .regWrData, .regWrEn,
    .regRdEn, .regRdData, .irq, .txByte, .txByteValid, .txByteReady,
    .txBit, .txBitValid, .txBitReady, .rxBit, .rxBitValid, .rxByte,
    .rxByteValid);
  air_link_model i_mod (.sys_clk, .rstn, .txBit, .txBitValid, .txBitReady,
    .rxBit, .rxBitValid);

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regWrEn <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge sys_clk);
    regWrEn <= 1'b0;
  endtask
  task automatic cmp(input string n, input logic [7:0] e,
                     input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rdCmp(input string n, input logic [7:0] a,
                       input logic [7:0] e);
    @(posedge sys_clk);
    regRdEn <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRdEn <= 1'b0;
    #1 cmp(n, e, regRdData);
  endtask
  // appends n bits msb first, folding them into the running crc
  task automatic addBits(input logic [31:0] v, input int n, input logic c);
    logic fb;
    for (int i = n - 1; i >= 0; i--) begin
      expQ.push_back(v[i]);
      fb = crc[7] ^ v[i];
      if (c) crc = {crc[6:0], 1'b0} ^ (fb ? 8'h07 : 8'h00);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  assign txByte = pay[payIdx[1:0]];
  always @(posedge sys_clk) begin
    cycCnt <= cycCnt + 1;
    if (txByteValid && txByteReady) payIdx <= payIdx + 1;
    if (rxByteValid === 1'b1) lastRx <= rxByte;
    if (cycCnt == 40000) begin
      error_cnt++;
      print_verdict();
    end
  end

  initial begin
    logic [3:0] pat;
    logic crcOn;
    int nPay;
    rstn = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    txByteValid = 1'b1;
    repeat (8) @(posedge sys_clk);
    rstn <= 1'b1;
    foreach (R0[i]) rdCmp("reset value", R0[i], 8'h00);
    wr(REG_LINK_QUAL, 8'hFF);
    rdCmp("read only", REG_LINK_QUAL, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(REG_SYNC_PRI1 + 8'(i), PRI[31 - 8 * i -: 8]);
      wr(REG_SYNC_SEC1 + 8'(i), SEC[31 - 8 * i -: 8]);
    end
    rdCmp("node addr", REG_NODE_ADDR, 8'h3C);
    wr(REG_MASK, 8'h01);
    wr(REG_PRE_CNT_LO, 8'h04);
    for (int k = 0; k < 3; k++) begin
      wr(REG_PKT_CTRL, C_CTRL[k]);
      wr(REG_PRE_SEL, C_SEL[k]);
      wr(REG_SYNC_LEN, C_SLEN[k]);
      wr(REG_TXLEN_LO, C_LEN[k]);
      wr(REG_POST_CNT, C_POST[k]);
      expQ.delete();
      crc = 8'hFF;
      crcOn = C_CTRL[k][CRC_EN_BIT];
      nPay = C_LEN[k];
      pat = C_CTRL[k][FSK4_BIT] ? PRE_PAT_4[C_SEL[k][1:0]]
                                : PRE_PAT_2[C_SEL[k][1:0]];
      for (int i = 0; i < 8; i++) expQ.push_back(pat[3 - i % 4]);
      addBits((C_CTRL[k][ALT_SYNC_BIT] ? SEC : PRI) >> (32 - C_SLEN[k]),
              C_SLEN[k], 1'b0);
      if (C_CTRL[k][VARLEN_BIT]) begin
        addBits({24'h0, C_LEN[k]}, C_CTRL[k][LENWID_BIT] ? 16 : 8, crcOn);
      end
      if (C_CTRL[k][ADDR_EN_BIT]) begin
        addBits(32'h3C, 8, crcOn);
        nPay--;
      end
      for (int i = 0; i < nPay; i++) addBits({24'h0, pay[i]}, 8, crcOn);
      if (crcOn) addBits({24'h0, crc}, 8, 1'b0);
      for (int i = 0; i < C_POST[k]; i++) addBits(32'h1, 2, 1'b0);
      i_mod.capBits.delete();
      payIdx <= 0;
      wr(REG_CMD, 8'h03);
      for (int i = 0; i < 5000 && irq !== 1'b1; i++) @(posedge sys_clk);
      cmp("irq set", 8'h01, {7'h0, irq});
      repeat (20) @(posedge sys_clk);
      cmp("frame size", 8'(expQ.size()), 8'(i_mod.capBits.size()));
      foreach (expQ[i]) begin
        cmp("air bit", {7'h0, expQ[i]}, {7'h0, i_mod.capBits[i]});
      end
      rdCmp("status", REG_STATUS, 8'h0B);
      cmp("irq clear", 8'h00, {7'h0, irq});
      rdCmp("quality", REG_LINK_QUAL, {1'b0, C_CTRL[k][ALT_SYNC_BIT],
            C_SLEN[k][5:0]});
      rdCmp("rx length", REG_RXLEN_LO, C_LEN[k]);
      cmp("rx byte", pay[nPay - 1], lastRx);
    end
    wr(REG_MASK, 8'h20);
    for (int f = 1; f < 4; f++) begin
      wr(REG_PKT_CTRL, 8'(f));
      wr(REG_CMD, 8'h01);
      for (int i = 0; i < 20 && irq !== 1'b1; i++) @(posedge sys_clk);
      cmp("irq format", 8'h01, {7'h0, irq});
      rdCmp("format status", REG_STATUS, 8'h20);
    end
    wr(REG_MASK, 8'h00);
    wr(REG_CMD, 8'h01);
    repeat (4) @(posedge sys_clk);
    cmp("irq masked", 8'h00, {7'h0, irq});
    rdCmp("masked status", REG_STATUS, 8'h20);
    print_verdict();
  end
endmodule // testbench
